// ---- core/nsr_host.sv ----
// Host controller driving the nonvolatile static RAM asynchronous port.
`timescale 1ns/1ps
`default_nettype none
`include "nsr_defines.svh"
module nsr_host (
    // Clock and reset.
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    // User request side.
    input  wire logic              I_REQ_VALID,
    input  wire nsr_pkg::nsr_req_s I_REQ,
    output logic                   O_REQ_READY,
    output logic                   O_RSP_VALID,
    output logic [15:0]            O_RSP_DATA,
    output logic                   O_MEM_BUSY,
    // Memory pins.
    output nsr_pkg::nsr_pins_s     O_PINS,
    input  wire logic [15:0]       I_DQ,
    input  wire logic              I_BUSY_N
);
    import nsr_pkg::*;

    nsr_state_s  s_ff;
    nsr_state_s  nxt_s;
    logic        busy_n_s;
    logic [15:0] dq_s;

    // Pin inputs come from the memory, outside this clock domain.
    // The data word needs no handshake: it stands for several cycles before it is taken.
    nsr_sync #(.W(1)) u_busy_sync (
        .i_clk (I_CLK),
        .i_rst (I_SYS_RST),
        .i_d   (I_BUSY_N),
        .o_q   (busy_n_s)
    );
    nsr_sync #(.W(16)) u_dq_sync (
        .i_clk (I_CLK),
        .i_rst (I_SYS_RST),
        .i_d   (I_DQ),
        .o_q   (dq_s)
    );

    // Address of one step of the software store sequence.
    function automatic logic [15:0] seq_addr(input logic [2:0] i);
        case (i)
            3'h0:    seq_addr = `NSR_SEQ_0;
            3'h1:    seq_addr = `NSR_SEQ_1;
            3'h2:    seq_addr = `NSR_SEQ_2;
            3'h3:    seq_addr = `NSR_SEQ_3;
            3'h4:    seq_addr = `NSR_SEQ_4;
            default: seq_addr = `NSR_SEQ_5;
        endcase
    endfunction

    // Idle pin state: deselected, strobes high, bus released.
    function automatic nsr_pins_s idle_pins();
        nsr_pins_s p;
        p         = '0;
        p.cs_n    = 1'b1;
        p.wr_n    = 1'b1;
        p.og_n    = 1'b1;
        p.ub_n    = 1'b1;
        p.lb_n    = 1'b1;
        idle_pins = p;
    endfunction

    // Per-bit mask of the selected byte lanes; bit 1 is the upper lane.
    function automatic logic [15:0] lane_mask(input logic [1:0] lanes);
        lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    // Busy as seen through the synchroniser; our own pull shows up here too.
    logic mem_busy;
    assign mem_busy = !busy_n_s;

    // Next-state logic for the whole host sequencer.
    // A read or write is one setup cycle, a five-cycle strobe and one hold cycle.
    // The strobe is two cycles longer than the access time because read data
    // crosses the two-flop synchroniser before it is taken.
    always_comb begin
        nxt_s     = s_ff;
        nxt_s.ack = 1'b0;
        unique case (s_ff.st)
            NSR_IDLE: begin
                nxt_s.pins = idle_pins();
                // New accesses wait while the memory reports busy.
                // A request held off here stays with the requester; nothing is dropped.
                if (I_REQ_VALID && !mem_busy) begin
                    nxt_s.req  = I_REQ;
                    nxt_s.seq  = 3'h0;
                    nxt_s.cnt  = 4'h0;
                    if (I_REQ.op == NSR_OP_HWST) begin
                        nxt_s.st = NSR_HREQ;
                    end else begin
                        nxt_s.st = NSR_SETUP;
                    end
                end
            end
            NSR_SETUP: begin
                // Address and lanes settle before any strobe falls.
                // A software store ignores the requested address and lanes.
                nxt_s.pins.cs_n = 1'b1;
                if (s_ff.req.op == NSR_OP_SWST) begin
                    nxt_s.pins.addr = seq_addr(s_ff.seq);
                    nxt_s.pins.ub_n = 1'b0;
                    nxt_s.pins.lb_n = 1'b0;
                end else begin
                    nxt_s.pins.addr = s_ff.req.addr;
                    nxt_s.pins.ub_n = !s_ff.req.lanes[1];
                    nxt_s.pins.lb_n = !s_ff.req.lanes[0];
                end
                if (s_ff.req.op == NSR_OP_WRITE) begin
                    nxt_s.pins.dq_o  = s_ff.req.wdata;
                    nxt_s.pins.dq_oe = lane_mask(s_ff.req.lanes);
                end
                nxt_s.cnt = s_ff.cnt + 4'h1;
                if (s_ff.cnt >= 4'(`NSR_SETUP_CYC - 1)) begin
                    nxt_s.cnt = 4'h0;
                    nxt_s.st  = NSR_STROBE;
                end
            end
            NSR_STROBE: begin
                // Address and lanes from setup stay unchanged through the strobe.
                nxt_s.pins.cs_n = 1'b0;
                if (s_ff.req.op == NSR_OP_WRITE) begin
                    // Output gate stays high through the write to avoid contention.
                    nxt_s.pins.wr_n = 1'b0;
                    nxt_s.pins.og_n = 1'b1;
                end else begin
                    nxt_s.pins.wr_n = 1'b1;
                    nxt_s.pins.og_n = 1'b0;
                end
                nxt_s.cnt = s_ff.cnt + 4'h1;
                // Read data is taken from the synchroniser at the end of the strobe.
                if (s_ff.cnt >= 4'(`NSR_ACCESS_CYC + 1)) begin
                    if (s_ff.req.op == NSR_OP_READ) begin
                        nxt_s.rdata = dq_s & lane_mask(s_ff.req.lanes);
                    end
                    nxt_s.cnt = 4'h0;
                    nxt_s.st  = NSR_HOLD;
                end
            end
            NSR_HOLD: begin
                // Strobes rise first; data and address hold past that edge.
                nxt_s.pins.cs_n = 1'b1;
                nxt_s.pins.wr_n = 1'b1;
                nxt_s.pins.og_n = 1'b1;
                nxt_s.cnt       = s_ff.cnt + 4'h1;
                if (s_ff.cnt >= 4'(`NSR_HOLD_CYC - 1)) begin
                    nxt_s.cnt        = 4'h0;
                    // Write data stays driven one cycle past the rising strobes.
                    if (s_ff.req.op == NSR_OP_SWST && s_ff.seq != 3'(`NSR_SEQ_LEN - 1)) begin
                        // Sequence reads follow back to back with no other access.
                        nxt_s.seq = s_ff.seq + 3'h1;
                        nxt_s.st  = NSR_SETUP;
                    end else if (s_ff.req.op == NSR_OP_SWST) begin
                        nxt_s.st = NSR_WAIT;
                    end else begin
                        nxt_s.st = NSR_DONE;
                    end
                end
            end
            NSR_HREQ: begin
                // Open-drain pull low: enable drives a zero.
                nxt_s.pins.busy_o  = 1'b0;
                nxt_s.pins.busy_oe = 1'b1;
                nxt_s.cnt          = s_ff.cnt + 4'h1;
                // The release is registered at the last counted edge, so count one further.
                if (s_ff.cnt >= 4'(`NSR_HREQ_CYC)) begin
                    nxt_s.pins.busy_oe = 1'b0;
                    nxt_s.cnt          = 4'h0;
                    nxt_s.st           = NSR_WAIT;
                end
            end
            NSR_WAIT: begin
                // Wait for our own pull to clear the synchroniser, then for busy to end.
                // A store run by the memory holds busy low far longer than this count.
                nxt_s.pins = idle_pins();
                nxt_s.cnt  = (s_ff.cnt == 4'hf) ? s_ff.cnt : s_ff.cnt + 4'h1;
                if (s_ff.cnt >= 4'h3 && !mem_busy) begin
                    nxt_s.st = NSR_DONE;
                end
            end
            NSR_DONE: begin
                // Data lines are released only now, after the hold cycle.
                nxt_s.pins.dq_oe = 16'h0000;
                nxt_s.ack = 1'b1;
                nxt_s.cnt = 4'h0;
                nxt_s.st  = NSR_IDLE;
            end
            default: begin
                nxt_s.st   = NSR_IDLE;
                nxt_s.pins = idle_pins();
            end
        endcase
    end

    // Single state register.
    // Reset leaves every strobe high so the memory sees no access while we are held.
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            s_ff           <= '0;
            s_ff.st        <= NSR_IDLE;
            s_ff.pins.cs_n <= 1'b1;
            s_ff.pins.wr_n <= 1'b1;
            s_ff.pins.og_n <= 1'b1;
            s_ff.pins.ub_n <= 1'b1;
            s_ff.pins.lb_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Ready only when idle and the memory is free.
    // The response pulse lasts one cycle; read data holds until the next read.
    assign O_REQ_READY = (s_ff.st == NSR_IDLE) && !mem_busy;
    assign O_RSP_VALID = s_ff.ack;
    assign O_RSP_DATA  = s_ff.rdata;
    assign O_MEM_BUSY  = mem_busy;
    assign O_PINS      = s_ff.pins;
endmodule
`default_nettype wire

// ---- core/nsr_defines.svh ----
// Constants for the nonvolatile static RAM host port controller.
`ifndef NSR_DEFINES_SVH
`define NSR_DEFINES_SVH

`define NSR_CLK_NS        20
// Host cycle phase lengths in nanoseconds and derived clock counts.
`define NSR_SETUP_NS      20
`define NSR_STROBE_NS     60
`define NSR_ACCESS_NS     60
`define NSR_HOLD_NS       20
`define NSR_SETUP_CYC     ((`NSR_SETUP_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_STROBE_CYC    ((`NSR_STROBE_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_ACCESS_CYC    ((`NSR_ACCESS_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_HOLD_CYC      ((`NSR_HOLD_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
// Software store address sequence.
`define NSR_SEQ_0         16'h4e38
`define NSR_SEQ_1         16'hb1c7
`define NSR_SEQ_2         16'h83e0
`define NSR_SEQ_3         16'h7c1f
`define NSR_SEQ_4         16'h703f
`define NSR_SEQ_5         16'h8fc0
`define NSR_SEQ_LEN       6
// Hardware store request pulse width in clocks.
`define NSR_HREQ_CYC      4

`endif

// ---- core/nsr_pkg.sv ----
// Types for the nonvolatile static RAM host port controller.
package nsr_pkg;

    typedef enum logic [1:0] {
        NSR_OP_READ  = 2'b00,
        NSR_OP_WRITE = 2'b01,
        NSR_OP_SWST  = 2'b10,
        NSR_OP_HWST  = 2'b11
    } nsr_op_e;

    // Host request: operation, word address and write data with lane enables.
    typedef struct packed {
        nsr_op_e     op;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  lanes;
    } nsr_req_s;

    // Pins driven toward the memory.
    typedef struct packed {
        logic        cs_n;
        logic        wr_n;
        logic        og_n;
        logic        ub_n;
        logic        lb_n;
        logic [15:0] addr;
        logic [15:0] dq_o;
        logic [15:0] dq_oe;
        logic        busy_o;
        logic        busy_oe;
    } nsr_pins_s;

    typedef enum logic [3:0] {
        NSR_IDLE   = 4'h0,
        NSR_SETUP  = 4'h1,
        NSR_STROBE = 4'h2,
        NSR_HOLD   = 4'h3,
        NSR_HREQ   = 4'h4,
        NSR_WAIT   = 4'h5,
        NSR_DONE   = 4'h6
    } nsr_state_e;

    typedef struct packed {
        nsr_state_e  st;
        nsr_req_s    req;
        nsr_pins_s   pins;
        logic [3:0]  cnt;
        logic [2:0]  seq;
        logic [15:0] rdata;
        logic        ack;
    } nsr_state_s;

endpackage

// ---- core/nsr_sync.sv ----
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module nsr_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Asynchronous input and synchronised output.
    input  wire logic [W-1:0] i_d,
    output logic [W-1:0]      o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end
    assign o_q = q_ff;
endmodule
`default_nettype wire

// ---- tb/nsr_host_props.sv ----
// Port-level checks of the host controller.
`timescale 1ns/1ps
`default_nettype none
module nsr_host_props (
    // Clock and reset.
    input wire logic               I_CLK,
    input wire logic               I_SYS_RST,
    // Request side.
    input wire logic               I_REQ_VALID,
    input wire nsr_pkg::nsr_req_s  I_REQ,
    input wire logic               O_REQ_READY,
    input wire logic               O_RSP_VALID,
    input wire logic [15:0]        O_RSP_DATA,
    input wire logic               O_MEM_BUSY,
    // Memory pins.
    input wire nsr_pkg::nsr_pins_s O_PINS,
    input wire logic [15:0]        I_DQ,
    input wire logic               I_BUSY_N
);
    import nsr_pkg::*;
    // All checks share the one clock and its reset.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    property p_gate_wr; !O_PINS.wr_n |-> O_PINS.og_n; endproperty
    a_gate_wr: assert property (p_gate_wr) else $error("gate low in write");
    property p_addr; !O_PINS.wr_n |-> $stable(O_PINS.addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved in write");
    property p_data; !O_PINS.wr_n |-> $stable(O_PINS.dq_o) && O_PINS.dq_oe != 16'h0; endproperty
    a_data: assert property (p_data) else $error("write data not held");
    // Data must still be driven at the edge that ends the strobe.
    property p_end; $rose(O_PINS.wr_n) |-> O_PINS.dq_oe == $past(O_PINS.dq_oe); endproperty
    a_end: assert property (p_end) else $error("data dropped at end");
    property p_wlen; $fell(O_PINS.wr_n) |-> (!O_PINS.wr_n && !O_PINS.cs_n)[*5] ##1 O_PINS.wr_n; endproperty
    a_wlen: assert property (p_wlen) else $error("strobe length wrong");
    property p_req; $rose(O_PINS.busy_oe) |-> (O_PINS.busy_oe && !O_PINS.busy_o)[*4] ##1 !O_PINS.busy_oe; endproperty
    a_req: assert property (p_req) else $error("store request pulse wrong");
    property p_rd; !O_PINS.og_n |-> O_PINS.wr_n && !O_PINS.cs_n && O_PINS.dq_oe == 16'h0; endproperty
    a_rd: assert property (p_rd) else $error("read cycle malformed");
    property p_busy; !I_BUSY_N [*3] |-> O_MEM_BUSY && !O_REQ_READY; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule
bind nsr_host nsr_host_props u_props (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REQ_VALID(I_REQ_VALID),
    .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID), .O_RSP_DATA(O_RSP_DATA),
    .O_MEM_BUSY(O_MEM_BUSY), .O_PINS(O_PINS), .I_DQ(I_DQ), .I_BUSY_N(I_BUSY_N));
`default_nettype wire

// ---- tb/nsr_mem_model.sv ----
// Behavioural model of the memory port and its store logic.
`timescale 1ns/1ps
`default_nettype none
module nsr_mem_model (
    // Pins from the host and resolved bus levels.
    input  wire nsr_pkg::nsr_pins_s i_pins,
    input  wire logic [15:0]        i_dq,
    input  wire logic               i_busy_n,
    // Model drive.
    output logic [15:0]             o_dq,
    output logic [15:0]             o_dq_oe,
    output logic                    o_busy_lo
);
    import nsr_pkg::*;
    logic [15:0] mem [0:65535];
    logic [15:0] tbl [6] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f, 16'h8fc0};
    logic        rd_on, wr_act = 1'b0, rd_act = 1'b0, pend = 1'b0, drv_hi = 1'b0;
    int          seq = 0, stores = 0;
    initial o_busy_lo = 1'b0;
    // Output follows the address while the read stays enabled.
    assign rd_on = !i_pins.cs_n && !i_pins.og_n && i_pins.wr_n && i_busy_n;
    assign o_dq = mem[i_pins.addr];
    assign o_dq_oe = {{8{rd_on && !i_pins.ub_n}}, {8{rd_on && !i_pins.lb_n}}};
    // A write opens only while busy is high, so one asked for during a store is lost.
    always @* if (!i_pins.cs_n && !i_pins.wr_n && i_busy_n) wr_act = 1'b1;
    always @* if (rd_on) rd_act = 1'b1;
    // Data lands on whichever end edge comes first.
    always @(posedge i_pins.wr_n or posedge i_pins.cs_n) begin
        if (wr_act) begin
            if (!i_pins.ub_n) mem[i_pins.addr][15:8] = i_dq[15:8];
            if (!i_pins.lb_n) mem[i_pins.addr][7:0] = i_dq[7:0];
            pend = 1'b1;
            seq = 0;
        end
        wr_act = 1'b0;
        if (rd_act) begin
            seq = (i_pins.addr == tbl[seq]) ? seq + 1 : int'(i_pins.addr == tbl[0]);
            if (seq == 6) store();
        end
        rd_act = 1'b0;
    end
    // A host pull only starts a store when a write is pending.
    always @(negedge i_busy_n) if (!o_busy_lo && pend) store();
    // A supply dip cuts the capacitor off the main supply and stores pending data on it.
    logic supply_low = 1'b0, cap_on_main = 1'b1, save_on_dip = 1'b1;
    always @(posedge supply_low) begin
        cap_on_main = 1'b0;
        if (pend && save_on_dip) store();
        cap_on_main = 1'b1;
    end
    // The pin is held low for the whole transfer, then driven high briefly before release.
    task automatic store();
        o_busy_lo = 1'b1;
        #400;
        o_busy_lo = 1'b0;
        drv_hi = 1'b1;
        pend = 1'b0;
        seq = 0;
        stores++;
        #40;
        drv_hi = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the host controller against the memory model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nsr_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, m_lo;
    nsr_req_s    req = '0;
    nsr_pins_s   pins;
    logic        ready, rsp_valid, mem_busy, busy_n;
    logic [15:0] rsp_data, dq_bus, m_dq, m_oe, got, dq_last = 16'h0;
    int          mismatches = 0, checks_done = 0;
    // Undriven data lines flip each cycle; busy has a pull-up and is driven high after a store.
    assign dq_bus = (pins.dq_oe & pins.dq_o) | (~pins.dq_oe & m_oe & m_dq) | (~pins.dq_oe & ~m_oe & ~dq_last);
    assign busy_n = u_mem.drv_hi || !(pins.busy_oe || m_lo);
    always @(posedge clk) dq_last <= dq_bus;
    nsr_host u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(ready),
        .O_RSP_VALID(rsp_valid), .O_RSP_DATA(rsp_data), .O_MEM_BUSY(mem_busy), .O_PINS(pins), .I_DQ(dq_bus),
        .I_BUSY_N(busy_n));
    nsr_mem_model u_mem (.i_pins(pins), .i_dq(dq_bus), .i_busy_n(busy_n), .o_dq(m_dq), .o_dq_oe(m_oe),
        .o_busy_lo(m_lo));
    initial forever #10 clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request, held until taken, then a bounded wait for its response.
    task automatic run(input nsr_op_e op, input logic [15:0] a, input logic [15:0] d, input logic [1:0] ln,
                       output int cyc);
        req_valid <= 1'b1;
        req <= '{op, a, d, ln};
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        cyc = 0;
        do begin @(posedge clk); cyc++; end while (rsp_valid !== 1'b1 && cyc < 300);
        got = rsp_data;
        check("response", 16'(cyc < 300), 16'h1);
    endtask
    // Back-to-back lane writes and reads; a lane not selected keeps its old byte.
    task automatic t_lanes();
        int c;
        run(NSR_OP_WRITE, 16'h1234, 16'ha5c3, 2'b11, c);
        run(NSR_OP_READ, 16'h1234, 16'h0, 2'b11, c);
        check("word", got, 16'ha5c3);
        run(NSR_OP_WRITE, 16'h1234, 16'h5a00, 2'b10, c);
        run(NSR_OP_READ, 16'h1234, 16'h0, 2'b01, c);
        check("lower lane", got, 16'h00c3);
        run(NSR_OP_READ, 16'h1234, 16'h0, 2'b10, c);
        check("upper lane", got, 16'h5a00);
    endtask
    // A hardware request stores only with a write pending; a software one always does.
    task automatic t_stores();
        int c, n;
        n = u_mem.stores;
        run(NSR_OP_HWST, 16'h0, 16'h0, 2'b00, c);
        check("hw store", 16'(u_mem.stores - n), 16'h1);
        check("hw wait", 16'(c > 20), 16'h1);
        run(NSR_OP_HWST, 16'h0, 16'h0, 2'b00, c);
        check("hw idle", 16'(u_mem.stores - n), 16'h1);
        check("hw quick", 16'(c < 20), 16'h1);
        run(NSR_OP_SWST, 16'h0, 16'h0, 2'b00, c);
        check("sw store", 16'(u_mem.stores - n), 16'h2);
        run(NSR_OP_READ, 16'h1234, 16'h0, 2'b11, c);
        check("kept", got, 16'h5ac3);
    endtask
    // A supply dip stores a pending write; with nothing pending it is ignored.
    task automatic t_power();
        int c, n;
        run(NSR_OP_WRITE, 16'h0042, 16'h1177, 2'b11, c);
        n = u_mem.stores;
        u_mem.supply_low <= 1'b1;
        repeat (10) @(posedge clk);
        check("busy seen", 16'(mem_busy), 16'h1);
        check("capacitor", 16'(u_mem.cap_on_main), 16'h0);
        u_mem.supply_low <= 1'b0;
        repeat (20) @(posedge clk);
        check("power store", 16'(u_mem.stores - n), 16'h1);
        u_mem.supply_low <= 1'b1;
        repeat (4) @(posedge clk);
        u_mem.supply_low <= 1'b0;
        check("power idle", 16'(mem_busy), 16'h0);
        run(NSR_OP_READ, 16'h0042, 16'h0, 2'b11, c);
        check("power kept", got, 16'h1177);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_lanes();
        t_stores();
        t_power();
        tally_and_finish();
    end
    // Whole run needs a few microseconds.
    initial begin
        #50us;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
